// ### hdl/nvp_pkg.sv
// package for the network value put block
`default_nettype none
package nvp_pkg;
  // Summary of operation
  // - rising trigger edge while idle latches operand into a buffer, then starts sending it
  // - operand is a signed 32-bit two's complement value
  // - trigger acknowledge follows the trigger input while it is active
  // - transfer status shows operand buffered and being passed to network
  // - failed send sets fault, held until next rising trigger edge
  // - up to 32 independent send block instances
  // - sends happen only while the station network is healthy
  // - status and fault outputs present from device revision 05 onward
  localparam int unsigned OPERAND_W = 32;
  localparam int unsigned MAX_BLOCKS = 32;
  localparam logic [7:0] FULL_REV = 8'h05;
  localparam logic signed [OPERAND_W-1:0] OPERAND_RST = 32'sh0000_0000;

  typedef enum logic [1:0] {
    NVP_IDLE,
    NVP_SEND,
    NVP_WAIT
  } nvp_state_e;

  // handshake toward the station network
  typedef struct packed {
    logic valid;
    logic signed [OPERAND_W-1:0] data;
    logic [4:0] block_id;
  } nvp_req_s;

  typedef struct packed {
    logic done;
    logic fail;
  } nvp_rsp_s;
endpackage : nvp_pkg
`default_nettype wire

// ### hdl/nvp_sync.sv
// two flip-flop synchroniser
`timescale 1ns/1ps
`default_nettype none
module nvp_sync (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic en_i,
  input wire logic d_i,
  output logic q_o
);
  logic s1_q;
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_q <= 1'b0;
      q_o <= 1'b0;
    end else if (en_i) begin
      s1_q <= d_i;
      q_o <= s1_q;
    end
  end
endmodule : nvp_sync
`default_nettype wire

// ### hdl/nvp_send.sv
// network value put send block
`timescale 1ns/1ps
`default_nettype none
module nvp_send #(
  parameter logic [4:0] BLOCK_ID = 5'h00,
  parameter logic [7:0] DEVICE_REV = nvp_pkg::FULL_REV
) (
  // clock and control
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  // user side
  input wire logic trigger_i,
  input wire logic signed [nvp_pkg::OPERAND_W-1:0] send_operand_i,
  input wire logic net_healthy_i,
  // network side
  output var nvp_pkg::nvp_req_s net_req_o,
  input wire nvp_pkg::nvp_rsp_s net_rsp_i,
  // status
  output logic trigger_ack_o,
  output logic xfer_in_progress_o,
  output logic xfer_fault_o
);
  localparam bit HAS_STATUS = (DEVICE_REV >= nvp_pkg::FULL_REV);

  function automatic logic is_idle(input nvp_pkg::nvp_state_e s);
    return s == nvp_pkg::NVP_IDLE;
  endfunction : is_idle

  logic [1:0] pin_raw;
  logic [1:0] pin_s;
  logic trig_s;
  logic health_s;
  logic trig_prev_q;
  logic rise;
  logic take;
  logic busy_d;
  logic signed [nvp_pkg::OPERAND_W-1:0] buf_q;
  nvp_pkg::nvp_state_e state_q;
  logic fault_q;

  // trigger and health come from pins
  assign pin_raw = {net_healthy_i, trigger_i};
  for (genvar g = 0; g < 2; g++) begin : g_pin_sync
    nvp_sync u_sync (
      .core_clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .en_i(clk_en_i),
      .d_i(pin_raw[g]),
      .q_o(pin_s[g])
    );
  end
  assign trig_s = pin_s[0];
  assign health_s = pin_s[1];

  assign rise = trig_s & ~trig_prev_q;
  // a rise during a running job starts nothing, so the buffer stays put
  assign take = rise && is_idle(state_q);
  // a job runs from its take until done, fail or health loss
  assign busy_d = is_idle(state_q) ? (take && health_s) :
    (health_s && !net_rsp_i.fail && !net_rsp_i.done);

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trig_prev_q <= 1'b0;
    end else if (clk_en_i) begin
      trig_prev_q <= trig_s;
    end
  end

  // acknowledge mirrors the synchronised trigger
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trigger_ack_o <= 1'b0;
    end else if (clk_en_i) begin
      trigger_ack_o <= trig_s;
    end
  end

  // operand buffer, only loaded on a rising trigger edge while idle, even with the network down
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      buf_q <= nvp_pkg::OPERAND_RST;
    end else if (clk_en_i && take) begin
      buf_q <= send_operand_i;
    end
  end

  // send sequencing
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= nvp_pkg::NVP_IDLE;
    end else if (clk_en_i) begin
      case (state_q)
        nvp_pkg::NVP_IDLE: begin
          if (take && health_s) begin
            state_q <= nvp_pkg::NVP_SEND;
          end
        end
        nvp_pkg::NVP_SEND: begin
          if (!health_s || net_rsp_i.fail || net_rsp_i.done) begin
            state_q <= nvp_pkg::NVP_IDLE;
          end else begin
            state_q <= nvp_pkg::NVP_WAIT;
          end
        end
        nvp_pkg::NVP_WAIT: begin
          if (!health_s || net_rsp_i.fail || net_rsp_i.done) begin
            state_q <= nvp_pkg::NVP_IDLE;
          end
        end
        default: begin
          state_q <= nvp_pkg::NVP_IDLE;
        end
      endcase
    end
  end

  // fault: set on failure or trigger without network, cleared by new job
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fault_q <= 1'b0;
    end else if (clk_en_i) begin
      if (take && !health_s) begin
        fault_q <= 1'b1;
      end else if (!is_idle(state_q) && (net_rsp_i.fail || !health_s)) begin
        fault_q <= 1'b1;
      end else if (take) begin
        fault_q <= 1'b0;
      end
    end
  end

  // request held for the whole job, peer picks it up unasked
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      net_req_o <= '0;
      xfer_in_progress_o <= 1'b0;
      xfer_fault_o <= 1'b0;
    end else if (clk_en_i) begin
      net_req_o.valid <= busy_d;
      net_req_o.data <= take ? send_operand_i : buf_q;
      net_req_o.block_id <= BLOCK_ID;
      xfer_in_progress_o <= HAS_STATUS && busy_d;
      xfer_fault_o <= HAS_STATUS && fault_q;
    end
  end

  // checks
  property p_ack_follows;
    @(posedge core_clk_i) disable iff (!nrst_i)
      clk_en_i |=> (trigger_ack_o == $past(trig_s));
  endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("ack does not follow trigger");

  property p_latch;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (clk_en_i && take) |=> (buf_q == $past(send_operand_i));
  endproperty
  a_latch: assert property (p_latch) else $error("operand not latched on rising edge");

  property p_hold;
    @(posedge core_clk_i) disable iff (!nrst_i)
      !take |=> $stable(buf_q);
  endproperty
  a_hold: assert property (p_hold) else $error("buffer changed without trigger");

  property p_no_send_unhealthy;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (clk_en_i && !health_s) |=> !net_req_o.valid;
  endproperty
  a_no_send_unhealthy: assert property (p_no_send_unhealthy) else $error("send while network down");

  property p_start;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (clk_en_i && rise && health_s && state_q == nvp_pkg::NVP_IDLE) |=>
        (net_req_o.valid && net_req_o.data == buf_q);
  endproperty
  a_start: assert property (p_start) else $error("send not started after trigger");

  property p_status;
    @(posedge core_clk_i) disable iff (!nrst_i)
      HAS_STATUS |-> (xfer_in_progress_o == net_req_o.valid);
  endproperty
  a_status: assert property (p_status) else $error("status disagrees with request");

  property p_fault_set;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (clk_en_i && state_q != nvp_pkg::NVP_IDLE && net_rsp_i.fail) |=> fault_q;
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault not set on failure");

  property p_fault_sticky;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (fault_q && !take) |=> fault_q;
  endproperty
  a_fault_sticky: assert property (p_fault_sticky) else $error("fault cleared without new job");

  property p_fault_clear;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (clk_en_i && take && health_s) |=> !fault_q;
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("fault not cleared by new job");

  property p_fault_out;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (clk_en_i && !HAS_STATUS) |=> !xfer_fault_o && !xfer_in_progress_o;
  endproperty
  a_fault_out: assert property (p_fault_out) else $error("status outputs on early revision");

  property p_stop;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (clk_en_i && !is_idle(state_q) && (net_rsp_i.done || net_rsp_i.fail)) |=> !net_req_o.valid;
  endproperty
  a_stop: assert property (p_stop) else $error("request kept after transfer ended");

  c_send_done: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
    net_req_o.valid ##[1:20] net_rsp_i.done);
  c_fail: cover property (@(posedge core_clk_i) disable iff (!nrst_i) $rose(xfer_fault_o));
  c_fault_clear: cover property (@(posedge core_clk_i) disable iff (!nrst_i) $fell(xfer_fault_o));
  c_retrig: cover property (@(posedge core_clk_i) disable iff (!nrst_i) rise && !is_idle(state_q));
endmodule : nvp_send
`default_nettype wire

// ### bench/nvp_net_model.sv
// peer station model that answers send jobs
`timescale 1ns/1ps
`default_nettype none
module nvp_net_model (
  // clock
  input wire logic core_clk_i,
  // behaviour control
  input wire logic fail_i,
  input wire logic [3:0] lat_i,
  // network
  input wire nvp_pkg::nvp_req_s req_i,
  output var nvp_pkg::nvp_rsp_s rsp_o,
  output logic signed [nvp_pkg::OPERAND_W-1:0] got_o
);
  logic [3:0] cnt_q;

  // one answer pulse per job, only while valid
  always_ff @(posedge core_clk_i) begin
    rsp_o <= '0;
    cnt_q <= req_i.valid ? cnt_q + 4'h1 : 4'h0;
    if (req_i.valid && cnt_q == lat_i) begin
      rsp_o.fail <= fail_i;
      rsp_o.done <= !fail_i;
      got_o <= req_i.data;
    end
  end
endmodule : nvp_net_model
`default_nettype wire

// ### bench/nvp_send_tb.sv
// testbench for the network value put block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; $display("Error %s exp %h got %h", n, e, g); end end
module nvp_send_tb;
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic trig = 1'b0;
  logic healthy = 1'b1;
  logic run = 1'b1;
  logic fail = 1'b0;
  logic [3:0] lat = 4'h0;
  logic signed [31:0] op = 32'sh0;
  logic signed [31:0] got;
  nvp_pkg::nvp_req_s req;
  nvp_pkg::nvp_rsp_s rsp;
  logic ack, prog, flt, ack4, prog4, flt4;
  int err_count = 0;
  int comparisons = 0;

  always #25 core_clk_i = ~core_clk_i;

  nvp_send #(.BLOCK_ID(5'h1F)) nvp_send_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .clk_en_i(run),
    .trigger_i(trig), .send_operand_i(op), .net_healthy_i(healthy), .net_req_o(req), .net_rsp_i(rsp),
    .trigger_ack_o(ack), .xfer_in_progress_o(prog), .xfer_fault_o(flt));
  // early revision without status outputs
  nvp_send #(.DEVICE_REV(8'h04)) nvp_send_old_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .clk_en_i(run),
    .trigger_i(trig), .send_operand_i(op), .net_healthy_i(healthy), .net_req_o(), .net_rsp_i(rsp),
    .trigger_ack_o(ack4), .xfer_in_progress_o(prog4), .xfer_fault_o(flt4));
  nvp_net_model nvp_net_model_inst (.core_clk_i(core_clk_i), .fail_i(fail), .lat_i(lat), .req_i(req),
    .rsp_o(rsp), .got_o(got));

  task automatic test_done();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  task automatic send(input logic signed [31:0] v, input logic f, input logic [3:0] l);
    int i;
    @(posedge core_clk_i);
    fail <= f;
    lat <= l;
    trig <= 1'b1;
    op <= v;
    repeat (3) @(posedge core_clk_i);
    #1;
    `CHK("ack", 1'b1, ack)
    `CHK("busy", 1'b1, prog)
    `CHK("data", v, req.data)
    `CHK("id", 5'h1F, req.block_id)
    `CHK("old busy", 1'b0, prog4)
    `CHK("old ack", 1'b1, ack4)
    @(posedge core_clk_i);
    op <= ~v;
    #1;
    i = 0;
    while (req.valid && i < 20) begin
      @(posedge core_clk_i);
      #1;
      i++;
    end
    @(posedge core_clk_i);
    #1;
    `CHK("ended", 1'b1, i < 20)
    `CHK("fault", f, flt)
    `CHK("old fault", 1'b0, flt4)
    `CHK("peer value", v, got)
    `CHK("ack held", 1'b1, ack)
    @(posedge core_clk_i);
    trig <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    #1;
    `CHK("ack off", 1'b0, ack)
    `CHK("fault kept", f, flt)
  endtask : send

  task automatic no_net();
    @(posedge core_clk_i);
    healthy <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    trig <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    #1;
    `CHK("no send", 1'b0, req.valid)
    `CHK("net fault", 1'b1, flt)
    @(posedge core_clk_i);
    trig <= 1'b0;
    healthy <= 1'b1;
    repeat (4) @(posedge core_clk_i);
  endtask : no_net

  // second trigger while a job runs must not touch the buffered value
  task automatic retrig();
    @(posedge core_clk_i);
    lat <= 4'h9;
    fail <= 1'b0;
    trig <= 1'b1;
    op <= 32'sh0000_1234;
    repeat (5) @(posedge core_clk_i);
    trig <= 1'b0;
    op <= 32'sh0000_5678;
    repeat (3) @(posedge core_clk_i);
    trig <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    #1;
    `CHK("job busy", 1'b1, prog)
    `CHK("held data", 32'sh0000_1234, req.data)
    `CHK("fault cleared", 1'b0, flt)
    repeat (6) @(posedge core_clk_i);
    #1;
    `CHK("peer kept", 32'sh0000_1234, got)
    `CHK("job done", 1'b0, req.valid)
    @(posedge core_clk_i);
    trig <= 1'b0;
    repeat (4) @(posedge core_clk_i);
  endtask : retrig

  // clock enable low freezes the block, a trigger seen only then is lost
  task automatic frozen();
    @(posedge core_clk_i);
    run <= 1'b0;
    trig <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    #1;
    `CHK("frozen ack", 1'b0, ack)
    `CHK("frozen send", 1'b0, req.valid)
    @(posedge core_clk_i);
    trig <= 1'b0;
    run <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    #1;
    `CHK("no late send", 1'b0, req.valid)
  endtask : frozen

  initial begin
    repeat (12) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    send(32'sh7FFFFFFF, 1'b0, 4'h0);
    no_net();
    send(32'shFFFFFFFF, 1'b0, 4'h2);
    send(32'sh80000000, 1'b1, 4'h7);
    retrig();
    frozen();
    test_done();
  end

  initial begin
    #100000;
    err_count++;
    test_done();
  end
endmodule : nvp_send_tb
`default_nettype wire
